//--- include/angr_pkg.sv
// Constants, types and field layout for the next-page and gigabit register slice.
// Assumes a single 200 MHz clock and a synchronous active-low reset.
//
// Behaviour
// RQ1: Outgoing next-page word writable; reset gives message page and code one.
// RQ2: Outgoing toggle bit 11 is inverse of previous sent codeword toggle.
// RQ3: Each received partner next page is captured; fields reset to zero.
// RQ4: Received toggle bit 11 uses same inverse-of-previous encoding.
// RQ5: Control bits 15:13 decode transmitter test mode; 101-111 reserved.
// RQ6: Bit 11 forces master/slave only while manual bit 12 set.
// RQ7: Bit 10 advertises multi-port when set, single-port when clear; resets 0.
// RQ8: Bits 9 and 8 advertise gigabit duplex; reset from configuration strap.
// RQ9: Status bit 15 latches high on master/slave fault until read.
// RQ10: Status bit 14 shows resolved role, 1 master; reads 1 after reset.
// RQ11: Status bits 13 and 12 show local and remote receiver okay.
// RQ12: Status bits 11 and 10 show partner gigabit duplex abilities.
// RQ13: Status bits 7:0 count idle errors, reset zero, clear on read.
// RQ14: Page-received indication latched until read.
// RQ15: Latched bits hold until read, then follow current condition.
// RQ16: Software loads next page early and reads received word after indication.
package angr_pkg;

    // ============================================================
    // Register offsets
    localparam logic [4:0] ANGR_ADDR_NP_TX = 5'h07;
    localparam logic [4:0] ANGR_ADDR_NP_RX = 5'h08;
    localparam logic [4:0] ANGR_ADDR_GCTRL = 5'h09;
    localparam logic [4:0] ANGR_ADDR_GSTAT = 5'h0a;
    localparam logic [4:0] ANGR_ADDR_IRQ_STAT = 5'h1c;
    localparam logic [4:0] ANGR_ADDR_IRQ_MASK = 5'h1d;

    // ============================================================
    // Field positions
    localparam int ANGR_NP_MORE = 15;
    localparam int ANGR_NP_ACK = 14;
    localparam int ANGR_NP_MSG = 13;
    localparam int ANGR_NP_ACK2 = 12;
    localparam int ANGR_NP_TOGGLE = 11;
    localparam int ANGR_GC_MANUAL = 12;
    localparam int ANGR_GC_MSVAL = 11;
    localparam int ANGR_GC_PORT = 10;
    localparam int ANGR_GC_FDX = 9;
    localparam int ANGR_GC_HDX = 8;
    localparam int ANGR_GS_FAULT = 15;
    localparam int ANGR_GS_ROLE = 14;
    localparam int ANGR_GS_LRX = 13;
    localparam int ANGR_GS_RRX = 12;
    localparam int ANGR_GS_LP_FDX = 11;
    localparam int ANGR_GS_LP_HDX = 10;

    // ============================================================
    // Reset values, next-page write mask and idle count maximum
    localparam logic [15:0] ANGR_NP_TX_RST = 16'h2001;
    localparam logic [15:0] ANGR_NP_RX_RST = 16'h0000;
    localparam logic [15:0] ANGR_GCTRL_RST = 16'h0000;
    localparam logic [15:0] ANGR_NP_TX_WMASK = 16'hb7ff;
    localparam logic [7:0] ANGR_IDLE_MAX = 8'hff;

    // Interrupt status bits
    localparam int ANGR_IRQ_PAGE = 0;
    localparam int ANGR_IRQ_FAULT = 1;
    localparam int ANGR_IRQ_IDLE = 2;
    localparam int ANGR_IRQ_W = 3;

    // ============================================================
    // Types
    typedef enum logic [4:0] {
        ANGR_TM_NORMAL = 5'b00001,
        ANGR_TM_WAVE = 5'b00010,
        ANGR_TM_JIT_M = 5'b00100,
        ANGR_TM_JIT_S = 5'b01000,
        ANGR_TM_DIST = 5'b10000
    } angr_test_e;

    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } angr_req_s;

    typedef struct packed {
        logic force_en;
        logic force_master;
        logic multi_port;
        logic adv_fdx;
        logic adv_hdx;
    } angr_adv_s;

endpackage

//--- rtl/angr_idle_cnt.sv
// Saturating idle error counter, cleared when its register is read.
// Assumes error pulses synchronous to clk_i.
module angr_idle_cnt
    import angr_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Events
    input wire logic err_i,
    input wire logic clr_i,
    // Count
    output logic [WIDTH-1:0] count_o
);
    // Clear value needs at least two bits
    if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
        $error("angr_idle_cnt: WIDTH out of range");
    end

    // Count taken on the read clears; a coincident error counts as one
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            count_o <= '0;
        end else if (clr_i) begin
            count_o <= {{(WIDTH-1){1'b0}}, err_i}; // RQ13
        end else if (err_i && count_o != {WIDTH{1'b1}}) begin
            count_o <= count_o + 1'b1;
        end
    end

    AST_IDLE_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ13
        clr_i && !err_i |=> count_o == '0)
        else $error("idle count not cleared after read");
endmodule

//--- rtl/angr_regs.sv
// Next-page, gigabit control and gigabit status management registers.
// Assumes the negotiation engine drives one-cycle page and codeword pulses.
module angr_regs
    import angr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Strap
    input wire logic [1:0] config_strap_value_i,
    // Management port
    input wire logic [4:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Negotiation engine
    input wire logic lcw_sent_i,
    input wire logic lcw_sent_toggle_i,
    input wire logic page_rx_i,
    input wire logic [15:0] page_rx_word_i,
    input wire logic ms_fault_i,
    input wire logic ms_master_i,
    input wire logic local_rx_ok_i,
    input wire logic remote_rx_ok_i,
    input wire logic link_partner_fdx_i,
    input wire logic link_partner_hdx_i,
    input wire logic idle_err_i,
    // Control outputs
    output logic [15:0] np_tx_word_o,
    output logic [4:0] test_mode_o,
    output logic force_en_o,
    output logic force_master_o,
    output logic multi_port_o,
    output logic adv_full_duplex_o,
    output logic adv_half_duplex_o,
    output logic page_rcvd_o,
    output logic irq_o
);
    // ============================================================
    // Storage
    angr_req_s req;
    angr_adv_s adv;
    logic [15:0] np_tx;
    logic tx_toggle;
    logic [15:0] np_rx;
    logic [15:0] gctrl;
    logic fault_lat;
    logic page_lat;
    logic role;
    logic [3:0] rx_health;
    logic [7:0] idle_cnt;
    logic [ANGR_IRQ_W-1:0] irq_stat;
    logic [ANGR_IRQ_W-1:0] irq_mask;
    logic [ANGR_IRQ_W-1:0] irq_ev;
    logic strap_done;
    logic rd_gstat;
    logic rd_nprx;
    logic [15:0] next_rdata;
    logic next_irq;
    logic [4:0] next_mode;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign rd_gstat = req.rd && req.addr == ANGR_ADDR_GSTAT;
    assign rd_nprx = req.rd && req.addr == ANGR_ADDR_NP_RX;

    // ============================================================
    // Outgoing next page
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            np_tx <= ANGR_NP_TX_RST; // RQ1
        end else if (req.wr && req.addr == ANGR_ADDR_NP_TX) begin
            np_tx <= req.wdata & ANGR_NP_TX_WMASK; // RQ1
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tx_toggle <= 1'b0;
        end else if (lcw_sent_i) begin
            tx_toggle <= ~lcw_sent_toggle_i; // RQ2
        end
    end

    // ============================================================
    // Received partner page
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            np_rx <= ANGR_NP_RX_RST; // RQ3
        end else if (page_rx_i) begin
            np_rx <= page_rx_word_i; // RQ3 RQ4
        end
    end

    // Set wins over the clearing read
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            page_lat <= 1'b0;
        end else if (page_rx_i) begin
            page_lat <= 1'b1; // RQ14
        end else if (rd_nprx) begin
            page_lat <= 1'b0; // RQ15
        end
    end

    // ============================================================
    // Gigabit control; duplex bits loaded from strap after reset release
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            gctrl <= ANGR_GCTRL_RST; // RQ7
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            gctrl[ANGR_GC_FDX] <= config_strap_value_i[1]; // RQ8
            gctrl[ANGR_GC_HDX] <= config_strap_value_i[0]; // RQ8
        end else if (req.wr && req.addr == ANGR_ADDR_GCTRL) begin
            gctrl <= req.wdata;
        end
    end

    always_comb begin
        unique case (gctrl[15:13]) // RQ5
            3'b000: next_mode = ANGR_TM_NORMAL;
            3'b001: next_mode = ANGR_TM_WAVE;
            3'b010: next_mode = ANGR_TM_JIT_M;
            3'b011: next_mode = ANGR_TM_JIT_S;
            3'b100: next_mode = ANGR_TM_DIST;
            default: next_mode = ANGR_TM_NORMAL;
        endcase
    end

    assign adv = '{
        force_en: gctrl[ANGR_GC_MANUAL],
        force_master: gctrl[ANGR_GC_MANUAL] & gctrl[ANGR_GC_MSVAL], // RQ6
        multi_port: gctrl[ANGR_GC_PORT], // RQ7
        adv_fdx: gctrl[ANGR_GC_FDX], // RQ8
        adv_hdx: gctrl[ANGR_GC_HDX] // RQ8
    };

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            test_mode_o <= ANGR_TM_NORMAL;
            force_en_o <= 1'b0;
            force_master_o <= 1'b0;
            multi_port_o <= 1'b0;
            adv_full_duplex_o <= 1'b0;
            adv_half_duplex_o <= 1'b0;
            np_tx_word_o <= ANGR_NP_TX_RST;
            page_rcvd_o <= 1'b0;
        end else begin
            test_mode_o <= next_mode;
            force_en_o <= adv.force_en;
            force_master_o <= adv.force_master;
            multi_port_o <= adv.multi_port;
            adv_full_duplex_o <= adv.adv_fdx;
            adv_half_duplex_o <= adv.adv_hdx;
            np_tx_word_o <= {np_tx[15:12], tx_toggle, np_tx[10:0]};
            page_rcvd_o <= page_lat;
        end
    end

    // ============================================================
    // Gigabit status
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            fault_lat <= 1'b0;
        end else if (ms_fault_i) begin
            fault_lat <= 1'b1; // RQ9
        end else if (rd_gstat) begin
            fault_lat <= 1'b0; // RQ15
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            role <= 1'b1; // RQ10
            rx_health <= 4'h0;
        end else begin
            role <= ms_master_i; // RQ10
            rx_health <= {local_rx_ok_i, remote_rx_ok_i, // RQ11
                link_partner_fdx_i, link_partner_hdx_i}; // RQ12
        end
    end

    angr_idle_cnt #(
        .WIDTH(8)
    ) u_idle (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .err_i(idle_err_i),
        .clr_i(rd_gstat), // RQ13
        .count_o(idle_cnt)
    );

    // ============================================================
    // Interrupts
    assign irq_ev = {idle_err_i, ms_fault_i, page_rx_i};

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= irq_ev | (irq_stat &
                ~((req.wr && req.addr == ANGR_ADDR_IRQ_STAT) ?
                req.wdata[ANGR_IRQ_W-1:0] : {ANGR_IRQ_W{1'b0}}));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_mask <= '0;
        end else if (req.wr && req.addr == ANGR_ADDR_IRQ_MASK) begin
            irq_mask <= req.wdata[ANGR_IRQ_W-1:0];
        end
    end

    assign next_irq = |(irq_ev | (irq_stat & irq_mask)) & |(irq_mask & (irq_ev | irq_stat));

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= next_irq;
        end
    end

    // ============================================================
    // Read data, one cycle after the strobe
    always_comb begin
        next_rdata = 16'h0000;
        unique case (req.addr)
            ANGR_ADDR_NP_TX: next_rdata = {np_tx[15:12], tx_toggle, np_tx[10:0]}; // RQ2
            ANGR_ADDR_NP_RX: next_rdata = np_rx;
            ANGR_ADDR_GCTRL: next_rdata = gctrl;
            ANGR_ADDR_GSTAT: next_rdata = {fault_lat, role, rx_health, 2'b00, idle_cnt};
            ANGR_ADDR_IRQ_STAT: next_rdata = {{(16-ANGR_IRQ_W){1'b0}}, irq_stat};
            ANGR_ADDR_IRQ_MASK: next_rdata = {{(16-ANGR_IRQ_W){1'b0}}, irq_mask};
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 16'h0000;
        end else if (req.rd) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // ============================================================
    // Checks
    // Page arrival and its two-step indication
    sequence s_page_in;
        page_rx_i;
    endsequence

    sequence s_page_shown;
        page_lat ##1 page_rcvd_o;
    endsequence

    // Release edge, after which the strap is loaded
    sequence s_release;
        !rstn_i ##1 rstn_i;
    endsequence

    AST_NP_RESET: assert property (@(posedge clk_i) // RQ1
        !rstn_i |=> np_tx == ANGR_NP_TX_RST && np_rx == 16'h0000)
        else $error("next page words wrong after reset");

    AST_NP_WRITE: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
        wr_i && addr_i == ANGR_ADDR_NP_TX |=> np_tx == ($past(wdata_i) & ANGR_NP_TX_WMASK))
        else $error("next page write not stored");

    AST_TOGGLE: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ2
        lcw_sent_i |=> tx_toggle == !$past(lcw_sent_toggle_i))
        else $error("outgoing toggle not inverse of sent codeword");

    AST_TOGGLE_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ2
        !lcw_sent_i |=> $stable(tx_toggle))
        else $error("outgoing toggle moved without a codeword");

    AST_RX_CAPTURE: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ3
        page_rx_i |=> np_rx == $past(page_rx_word_i))
        else $error("received page not captured");

    AST_RX_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ3
        !page_rx_i |=> $stable(np_rx))
        else $error("received page changed without arrival");

    AST_MODE: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ5
        gctrl[15:13] == 3'b100 |=> test_mode_o == ANGR_TM_DIST)
        else $error("distortion test mode not decoded");

    AST_MODE_ONEHOT: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ5
        1'b1 |=> $onehot(test_mode_o))
        else $error("test mode output not one-hot");

    AST_FORCE: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ6
        !gctrl[ANGR_GC_MANUAL] |=> !force_master_o)
        else $error("master value used without manual bit");

    AST_PORT: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ7
        gctrl[ANGR_GC_PORT] |=> multi_port_o)
        else $error("multi-port type not advertised");

    AST_STRAP: assert property (@(posedge clk_i) // RQ8
        s_release |=> gctrl[ANGR_GC_FDX] == $past(config_strap_value_i[1])
            && gctrl[ANGR_GC_HDX] == $past(config_strap_value_i[0]))
        else $error("duplex abilities not loaded from strap");

    AST_FAULT_SET: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ9
        ms_fault_i |=> fault_lat)
        else $error("fault not latched");

    AST_FAULT_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ9
        ms_fault_i ##1 (!rd_gstat) [*2] |=> fault_lat)
        else $error("fault latch dropped without read");

    AST_ROLE_RST: assert property (@(posedge clk_i) // RQ10
        !rstn_i |=> role)
        else $error("role not master after reset");

    AST_ROLE: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ10
        1'b1 |=> role == $past(ms_master_i))
        else $error("resolved role not reported");

    AST_HEALTH: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ11
        1'b1 |=> rx_health[3:2] == $past({local_rx_ok_i, remote_rx_ok_i}))
        else $error("receiver health not reported");

    AST_LP_ABIL: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ12
        1'b1 |=> rx_health[1:0] == $past({link_partner_fdx_i, link_partner_hdx_i}))
        else $error("partner abilities not reported");

    AST_IDLE_READ: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ13
        rd_gstat |=> rdata_o[7:0] == $past(idle_cnt))
        else $error("idle count not returned on read");

    AST_PAGE_LATCH: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ14
        s_page_in |=> s_page_shown)
        else $error("page received not latched");

    AST_CLEAR_ON_READ: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ15
        rd_nprx && !page_rx_i |=> !page_lat)
        else $error("page latch not cleared by read");

    AST_GS_CLEAR: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ15
        rd_gstat && !ms_fault_i |=> !fault_lat)
        else $error("fault latch not cleared by read");
endmodule

//--- testbench/angr_lp.sv
// Link partner and negotiation engine stand-in for the register slice.
// Assumes the shared clock; all outputs change just after rising edges.
module angr_lp (
    // Clock
    input wire logic clk_i,
    // Engine events
    output logic lcw_sent_o,
    output logic lcw_tog_o,
    output logic page_o,
    output logic [15:0] word_o,
    output logic fault_o,
    output logic idle_o,
    // Partner levels
    output logic [4:0] lv_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {lcw_sent_o, lcw_tog_o, page_o, fault_o, idle_o} = 5'h00;
        word_o = 16'h0000;
        lv_o = 5'h10;
    end
    // ============================================================
    // Single-cycle events and an n-cycle idle error burst
    task automatic link_codeword(input logic t);
        @(posedge clk_i);
        lcw_sent_o <= 1'b1;
        lcw_tog_o <= t;
        @(posedge clk_i);
        lcw_sent_o <= 1'b0;
        lcw_tog_o <= ~t;
    endtask
    // Word released after the pulse: show its inverse
    task automatic page(input logic [15:0] w);
        @(posedge clk_i);
        page_o <= 1'b1;
        word_o <= w;
        @(posedge clk_i);
        page_o <= 1'b0;
        word_o <= ~w;
    endtask
    task automatic fault();
        @(posedge clk_i);
        fault_o <= 1'b1;
        @(posedge clk_i);
        fault_o <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_i);
            idle_o <= 1'b1;
        end
        @(posedge clk_i);
        idle_o <= 1'b0;
    endtask
    // Order: master, local ok, remote ok, full, half
    task automatic lv(input logic [4:0] v);
        @(posedge clk_i);
        lv_o <= v;
    endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the next-page and gigabit register slice.
// Assumes the partner model drives all engine inputs.
module tb
    import angr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0] a;
        logic [15:0] d;
        logic [15:0] r;
        logic [9:0] c;
    } angr_row_s;
    logic clk_i, rstn_i, wr_i, rd_i;
    logic [1:0] strap;
    logic [4:0] addr_i;
    logic [15:0] wdata_i, rdata_o, np_o, v;
    logic link_codeword, tog, pg, flt, idl;
    logic [15:0] pw;
    logic [4:0] lv, tm;
    logic fe, fm, mp, af, ah, prc, irq_o;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    angr_row_s rows[14] = '{
        '{5'h07, 16'hffff, 16'hb7ff, 10'h022}, '{5'h07, 16'h0000, 16'h0000, 10'h022},
        '{5'h08, 16'hffff, 16'h0000, 10'h022}, '{5'h0a, 16'hffff, 16'h4000, 10'h022},
        '{5'h1e, 16'hffff, 16'h0000, 10'h022}, '{5'h09, 16'h0000, 16'h0000, 10'h020},
        '{5'h09, 16'h2000, 16'h2000, 10'h040}, '{5'h09, 16'h4000, 16'h4000, 10'h080},
        '{5'h09, 16'h6000, 16'h6000, 10'h100}, '{5'h09, 16'h8000, 16'h8000, 10'h200},
        '{5'h09, 16'ha000, 16'ha000, 10'h020}, '{5'h09, 16'hd800, 16'hd800, 10'h038},
        '{5'h09, 16'he8a5, 16'he8a5, 10'h020}, '{5'h09, 16'h1700, 16'h1700, 10'h037}};
    angr_regs u_angr_regs (.clk_i(clk_i), .rstn_i(rstn_i), .config_strap_value_i(strap),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .lcw_sent_i(link_codeword), .lcw_sent_toggle_i(tog), .page_rx_i(pg), .page_rx_word_i(pw),
        .ms_fault_i(flt), .ms_master_i(lv[4]), .local_rx_ok_i(lv[3]),
        .remote_rx_ok_i(lv[2]), .link_partner_fdx_i(lv[1]), .link_partner_hdx_i(lv[0]),
        .idle_err_i(idl), .np_tx_word_o(np_o), .test_mode_o(tm), .force_en_o(fe),
        .force_master_o(fm), .multi_port_o(mp), .adv_full_duplex_o(af),
        .adv_half_duplex_o(ah), .page_rcvd_o(prc), .irq_o(irq_o));
    angr_lp u_angr_lp (.clk_i(clk_i), .lcw_sent_o(link_codeword), .lcw_tog_o(tog), .page_o(pg),
        .word_o(pw), .fault_o(flt), .idle_o(idl), .lv_o(lv));
    initial clk_i = 1'b0;
    always #2.5 clk_i = ~clk_i;
    // ============================================================
    // Bus and check tasks
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic chk(input string s, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", s, exp, got);
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Reset with a given strap, then reset values
    task automatic do_rst(input logic [1:0] s);
        rstn_i <= 1'b0;
        strap <= s;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        waitc(2);
        chk("page latch", {15'h0, prc}, 16'h0000);
        rd(5'h07, v);
        chk("np tx rst", v, 16'h2001);
        rd(5'h08, v);
        chk("np rx rst", v, 16'h0000);
        rd(5'h09, v);
        chk("gctrl rst", v, {6'h00, s, 8'h00});
        rd(5'h0a, v);
        chk("gstat rst", v, 16'h4000);
        $display("test reset done");
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        {rstn_i, wr_i, rd_i} = 3'b000;
        strap = 2'b10;
        addr_i = 5'h00;
        wdata_i = 16'h0000;
        do_rst(2'b10);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk("row read", v, rows[i].r);
            chk("row ctl", {6'h00, tm, fe, fm, mp, af, ah}, {6'h00, rows[i].c});
        end
        $display("test table done");
        wr(5'h07, 16'h9555);
        u_angr_lp.link_codeword(1'b0);
        waitc(3);
        rd(5'h07, v);
        chk("toggle one", v, 16'h9d55);
        chk("np word out", np_o, 16'h9d55);
        u_angr_lp.link_codeword(1'b1);
        waitc(3);
        rd(5'h07, v);
        chk("toggle zero", v, 16'h9555);
        $display("test toggle done");
        wr(5'h1d, 16'h0007);
        u_angr_lp.page(16'hfabc);
        waitc(3);
        chk("page set", {15'h0, prc}, 16'h0001);
        chk("irq raised", {15'h0, irq_o}, 16'h0001);
        wr(5'h1d, 16'h0000);
        waitc(2);
        chk("irq masked", {15'h0, irq_o}, 16'h0000);
        rd(5'h1c, v);
        chk("irq status", v, 16'h0001);
        wr(5'h1c, 16'h0007);
        waitc(2);
        rd(5'h1c, v);
        chk("irq clear", v, 16'h0000);
        rd(5'h08, v);
        chk("rx word", v, 16'hfabc);
        waitc(2);
        chk("page clear", {15'h0, prc}, 16'h0000);
        $display("test page done");
        u_angr_lp.lv(5'b01010);
        u_angr_lp.idle(3);
        u_angr_lp.fault();
        waitc(3);
        rd(5'h0a, v);
        chk("status latched", v, 16'ha803);
        rd(5'h0a, v);
        chk("status after read", v, 16'h2800);
        u_angr_lp.idle(300);
        waitc(3);
        rd(5'h0a, v);
        chk("idle saturate", v, 16'h28ff);
        u_angr_lp.lv(5'b00101);
        waitc(2);
        rd(5'h0a, v);
        chk("status far ok", v, 16'h1400);
        $display("test status done");
        u_angr_lp.lv(5'b10000);
        u_angr_lp.page(16'h1234);
        do_rst(2'b01);
        end_sim();
    end
endmodule
